// ===== pscl_host.sv
// Behavioural download-cable host that loads serial images into the loader.
`timescale 1ns/100ps
`default_nettype none

module pscl_host (
    // Clock and the shared wires as the cable sees them.
    input wire logic clk_i,
    input wire logic status_n_i,
    input wire logic complete_i,
    // Cable outputs.
    output logic request_n_o,
    output logic sclk_o,
    output logic data_o
);
    // ==========================================================
    // Load sequence
    // ==========================================================
    // Request idles high; clock and data are parked high by their pull-ups.
    initial begin
        request_n_o = 1'b1;
        sclk_o = 1'b1;
        data_o = 1'b1;
    end

    // Pulses the request, waits for status, then clocks bits out MSB first.
    // A rude host skips the status wait, which the device must refuse.
    task automatic load(input logic [63:0] img, input int nbits, input int half, input bit rude);
        int w;
        w = 0;
        @(posedge clk_i);
        #1 request_n_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 request_n_o = 1'b1;
        while (!rude && status_n_i !== 1'b1 && w < 100) begin
            @(posedge clk_i);
            w++;
        end
        for (int i = 0; i < nbits && complete_i !== 1'b1; i++) begin
            @(posedge clk_i);
            #1 sclk_o = 1'b0;
            data_o = img[63 - i];
            repeat (half) @(posedge clk_i);
            #1 sclk_o = 1'b1;
            repeat (half - 1) @(posedge clk_i);
        end
        // The clock stands high and the released data line is pulled up.
        @(posedge clk_i);
        #1 data_o = 1'b1;
    endtask : load
endmodule : pscl_host
`default_nettype wire

// ===== pscl_loader.sv
// Device-side passive serial configuration loader top module.
`timescale 1ns/100ps
`default_nettype none

module pscl_loader #(
    // Power-on reset length in reference clock cycles.
    parameter int unsigned POR_CYCLES = pscl_pkg::POR_CYCLES,
    // Number of image bits, the last SUM_W of them carry the checksum.
    parameter int unsigned IMAGE_BITS = 64
) (
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Configuration request from the host.
    input wire logic CONFIG_REQUEST_N_I,
    // Serial clock and data from the host.
    input wire logic CONFIG_SERIAL_CLOCK_I,
    input wire logic SERIAL_CONFIG_DATA_I,
    // Open-drain status line.
    input wire logic CONFIG_STATUS_N_I,
    output logic CONFIG_STATUS_N_O,
    output logic CONFIG_STATUS_N_OE_O,
    // Open-drain completion line.
    input wire logic LOAD_COMPLETE_I,
    output logic LOAD_COMPLETE_O,
    output logic LOAD_COMPLETE_OE_O,
    // Chain enable in and out.
    input wire logic CHAIN_ENABLE_IN_N_I,
    output logic CHAIN_ENABLE_OUT_N_O,
    // User mode flag; user I/O stay high impedance while low.
    output logic USER_MODE_O,
    output logic USER_IO_HIZ_O,
    // Error flag, set while a checksum failure is held on status.
    output logic CONFIG_ERROR_O
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Two stage synchronisers for all pins; bit order req,clk,data,stat,done,ce.
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync1_nxt;
    // Previous synchronised serial clock for edge detection.
    logic sclk_d_r;

    always_comb begin
        sync1_nxt = {CONFIG_REQUEST_N_I, CONFIG_SERIAL_CLOCK_I, SERIAL_CONFIG_DATA_I,
                     CONFIG_STATUS_N_I, LOAD_COMPLETE_I, CHAIN_ENABLE_IN_N_I};
    end

    // Registers the synchronisers; reset loads the idle levels so no false clock edge follows.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync1_r <= pscl_pkg::SYNC_RESET;
            sync2_r <= pscl_pkg::SYNC_RESET;
            sclk_d_r <= pscl_pkg::SYNC_RESET[4];
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[4];
        end
    end

    // Synchronised levels.
    logic req_n_s, sclk_s, data_s, stat_n_s, done_s, ce_n_s;
    assign {req_n_s, sclk_s, data_s, stat_n_s, done_s, ce_n_s} = sync2_r;
    // Rising edge of the serial clock.
    logic sclk_rise;
    assign sclk_rise = sclk_s & ~sclk_d_r;

    // ==========================================================
    // Stage machine
    // ==========================================================
    pscl_pkg::pscl_state_e state_r, state_nxt;
    logic [pscl_pkg::CYC_CNT_W-1:0] cyc_r, cyc_nxt;     // Power-on and init counter.
    logic [pscl_pkg::BIT_CNT_W-1:0] bits_r, bits_nxt;   // Bits received.
    logic [pscl_pkg::SUM_W-1:0] sum_r, sum_nxt;         // Running checksum of payload.
    logic [pscl_pkg::SUM_W-1:0] rx_r, rx_nxt;           // Received checksum field.
    logic stat_drive_r, stat_drive_nxt;                 // Pulling status low.
    logic done_rel_r, done_rel_nxt;                     // Completion released.

    // Computes the next stage and counters.
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        bits_nxt = bits_r;
        sum_nxt = sum_r;
        rx_nxt = rx_r;
        stat_drive_nxt = stat_drive_r;
        done_rel_nxt = done_rel_r;
        case (state_r)
            // Hold status low for the power-on time.
            pscl_pkg::ST_POR: begin
                stat_drive_nxt = 1'b1;
                cyc_nxt = cyc_r + 1'b1;
                if (cyc_r >= POR_CYCLES - 1) begin
                    stat_drive_nxt = 1'b0;
                    state_nxt = pscl_pkg::ST_RESET;
                end
            end
            // Reset stage: hold status low while the request is low, then wait for it to rise.
            pscl_pkg::ST_RESET: begin
                bits_nxt = '0;
                sum_nxt = '0;
                rx_nxt = '0;
                done_rel_nxt = 1'b0;
                stat_drive_nxt = ~req_n_s;
                if (req_n_s) begin
                    state_nxt = pscl_pkg::ST_WAIT_STATUS;
                end
            end
            // Status released; wait for the line to rise.
            pscl_pkg::ST_WAIT_STATUS: begin
                if (!req_n_s) begin
                    state_nxt = pscl_pkg::ST_RESET;
                end else if (stat_n_s) begin
                    state_nxt = pscl_pkg::ST_CONFIG;
                end
            end
            // Take one bit per rising serial clock edge.
            pscl_pkg::ST_CONFIG: begin
                if (!req_n_s || !stat_n_s) begin
                    state_nxt = pscl_pkg::ST_RESET;
                end else if (sclk_rise && !ce_n_s) begin
                    bits_nxt = bits_r + 1'b1;
                    if (bits_r < IMAGE_BITS - pscl_pkg::SUM_W) begin
                        sum_nxt = {sum_r[pscl_pkg::SUM_W-2:0], sum_r[pscl_pkg::SUM_W-1] ^ data_s};
                    end else begin
                        rx_nxt = {rx_r[pscl_pkg::SUM_W-2:0], data_s};
                    end
                    if (bits_r == IMAGE_BITS - 1) begin
                        if ({rx_r[pscl_pkg::SUM_W-2:0], data_s} == sum_r) begin
                            done_rel_nxt = 1'b1;
                            cyc_nxt = '0;
                            state_nxt = pscl_pkg::ST_INIT;
                        end else begin
                            stat_drive_nxt = 1'b1;
                            state_nxt = pscl_pkg::ST_ERROR;
                        end
                    end
                end
            end
            // Error: hold status low until the host pulls the request low.
            pscl_pkg::ST_ERROR: begin
                if (!req_n_s) begin
                    // Status stays low; the reset stage keeps it so without a glitch.
                    state_nxt = pscl_pkg::ST_RESET;
                end
            end
            // Initialization on the internal clock once the shared line is high.
            pscl_pkg::ST_INIT: begin
                if (!req_n_s || !stat_n_s) begin
                    state_nxt = pscl_pkg::ST_RESET;
                end else if (done_s) begin
                    cyc_nxt = cyc_r + 1'b1;
                    if (cyc_r >= pscl_pkg::INIT_CYCLES - 1) begin
                        state_nxt = pscl_pkg::ST_USER;
                    end
                end
            end
            // User mode until a new request.
            pscl_pkg::ST_USER: begin
                if (!req_n_s) begin
                    state_nxt = pscl_pkg::ST_RESET;
                end
            end
            default: begin
                state_nxt = pscl_pkg::ST_RESET;
            end
        endcase
    end

    // Registers the stage machine.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= pscl_pkg::ST_POR;
            cyc_r <= '0;
            bits_r <= '0;
            sum_r <= '0;
            rx_r <= '0;
            stat_drive_r <= 1'b1;
            done_rel_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            bits_r <= bits_nxt;
            sum_r <= sum_nxt;
            rx_r <= rx_nxt;
            stat_drive_r <= stat_drive_nxt;
            done_rel_r <= done_rel_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Open-drain lines drive only low.
    assign CONFIG_STATUS_N_O = 1'b0;
    assign CONFIG_STATUS_N_OE_O = stat_drive_r;
    assign LOAD_COMPLETE_O = 1'b0;
    assign LOAD_COMPLETE_OE_O = ~done_rel_r;
    // Chain passes enable on once this device completed.
    assign CHAIN_ENABLE_OUT_N_O = ~done_rel_r;
    assign USER_MODE_O = (state_r == pscl_pkg::ST_USER);
    assign USER_IO_HIZ_O = ~USER_MODE_O;
    assign CONFIG_ERROR_O = (state_r == pscl_pkg::ST_ERROR);

    // ==========================================================
    // Assertions
    // ==========================================================
    a_por_status_low: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_POR) |-> CONFIG_STATUS_N_OE_O)
        else $error("Status not held low during power-on reset.");
    a_hiz_before_user: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        $rose(USER_MODE_O) |-> ($past(state_r) == pscl_pkg::ST_INIT && !USER_IO_HIZ_O))
        else $error("User I/O released outside the end of initialization.");
    a_status_in_reset: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_RESET && !req_n_s) |=> CONFIG_STATUS_N_OE_O)
        else $error("Status not held low while the request is low.");
    a_reset_on_req: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (!req_n_s && state_r inside {pscl_pkg::ST_CONFIG, pscl_pkg::ST_WAIT_STATUS})
        |=> (state_r == pscl_pkg::ST_RESET))
        else $error("Low request did not force reset stage.");
    a_req_leaves_reset: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_RESET && req_n_s)
        |=> (state_r == pscl_pkg::ST_WAIT_STATUS && !CONFIG_STATUS_N_OE_O))
        else $error("Request high did not start configuration.");
    a_no_bits_early: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_WAIT_STATUS) |=> $stable(bits_r))
        else $error("Bit taken before status rose.");
    a_shared_stop: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_CONFIG && !stat_n_s) |=> (state_r == pscl_pkg::ST_RESET))
        else $error("Shared status low did not stop configuration.");
    a_bit_on_edge: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_CONFIG && req_n_s && stat_n_s && sclk_rise && !ce_n_s)
        |=> (bits_r == $past(bits_r) + 1'b1))
        else $error("Serial clock edge did not take a bit.");
    a_done_held_low: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r inside {pscl_pkg::ST_CONFIG, pscl_pkg::ST_ERROR}) |-> LOAD_COMPLETE_OE_O)
        else $error("Completion released before clean image.");
    a_init_to_user: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_r == pscl_pkg::ST_INIT && done_s && req_n_s && stat_n_s
         && cyc_r == pscl_pkg::INIT_CYCLES - 1) |=> USER_MODE_O)
        else $error("User mode not entered after init count.");

endmodule : pscl_loader

`default_nettype wire

// ===== pscl_pkg.sv
// Package of constants and types for the passive serial configuration loader.
package pscl_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    // Clock period of the reference clock in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Power-on reset time in milliseconds.
    localparam int unsigned POR_TIME_MS = 100;
    // Power-on reset time in reference clock cycles.
    localparam int unsigned POR_CYCLES = 32'((POR_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS);
    // Initialization clock cycles after completion before user mode.
    localparam int unsigned INIT_CYCLES = 299;

    // ==========================================================
    // Image and counters
    // ==========================================================
    // Width of the bit counter for the configuration image.
    localparam int unsigned BIT_CNT_W = 32;
    // Width of the general purpose cycle counter.
    localparam int unsigned CYC_CNT_W = 32;
    // Width of the checksum accumulator.
    localparam int unsigned SUM_W = 16;
    // Synchroniser reset pattern, bit order req,clk,data,stat,done,ce: request, serial clock
    // and data at their parked high level, status and completion low as held in reset.
    localparam logic [5:0] SYNC_RESET = 6'h38;

    // ==========================================================
    // Types
    // ==========================================================
    // Stages of the loader.
    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_WAIT_STATUS,
        ST_CONFIG,
        ST_ERROR,
        ST_INIT,
        ST_USER
    } pscl_state_e;

endpackage : pscl_pkg

// ===== testbench.sv
// Self-checking testbench for the passive serial configuration loader.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // Shortened power-on count for simulation.
    localparam int unsigned POR_TEST = 20;
    logic clk, rst_n, request_n, sclk, data, chain_n;
    logic ext_stat_low, ext_comp_low, status_wire, comp_wire;
    logic status_oe, comp_oe, chain_out_n, user_mode, hiz, err;
    logic status_out, comp_out;
    logic [63:0] img;
    int mismatches, comparisons, cycles, seed, since, w;

    // Open-drain wires: pulled up, showing the driven value while a driver is enabled.
    assign status_wire = (status_oe ? status_out : 1'b1) & !ext_stat_low;
    assign comp_wire = (comp_oe ? comp_out : 1'b1) & !ext_comp_low;

    // 250 MHz reference clock.
    initial clk = 1'b0;
    always #2 clk = ~clk;

    pscl_loader #(.POR_CYCLES(POR_TEST), .IMAGE_BITS(64)) dut (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CONFIG_REQUEST_N_I(request_n),
        .CONFIG_SERIAL_CLOCK_I(sclk), .SERIAL_CONFIG_DATA_I(data),
        .CONFIG_STATUS_N_I(status_wire), .CONFIG_STATUS_N_O(status_out),
        .CONFIG_STATUS_N_OE_O(status_oe), .LOAD_COMPLETE_I(comp_wire),
        .LOAD_COMPLETE_O(comp_out), .LOAD_COMPLETE_OE_O(comp_oe),
        .CHAIN_ENABLE_IN_N_I(chain_n), .CHAIN_ENABLE_OUT_N_O(chain_out_n),
        .USER_MODE_O(user_mode), .USER_IO_HIZ_O(hiz), .CONFIG_ERROR_O(err));

    pscl_host host (.clk_i(clk), .status_n_i(status_wire), .complete_i(comp_wire),
        .request_n_o(request_n), .sclk_o(sclk), .data_o(data));

    // ==========================================================
    // Model and checks
    // ==========================================================
    // Builds a random image: 48 payload bits then their rotate-xor sum.
    function automatic logic [63:0] mk_image();
        logic [63:0] r;
        int q[$];
        int s;
        r = {$random(seed), $random(seed)};
        s = 0;
        for (int i = 63; i >= 16; i--) q.push_back(int'(r[i]));
        foreach (q[k]) s = ((s << 1) & 'hffff) | (((s >> 15) & 1) ^ q[k]);
        return {r[63:16], s[15:0]};
    endfunction : mk_image

    // Compares one flag and counts the result.
    task automatic check(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Counts cycles since the shared completion wire went high; cuts hangs.
    always @(posedge clk) begin
        since <= (comp_wire === 1'b1) ? since + 1 : 0;
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            finish_test();
        end
    end

    // Waits for user mode and checks when it came and what it released.
    task automatic check_init(input string name);
        w = 0;
        while (user_mode !== 1'b1 && w < 2000) begin
            @(posedge clk);
            #1 w++;
        end
        check(since >= 297 && since <= 305, 1'b1, "init count");
        check(hiz, 1'b0, "user io");
        check(chain_out_n, 1'b0, "chain out");
        $display("test %s done", name);
    endtask : check_init

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rst_n, ext_stat_low, ext_comp_low, chain_n} = 4'h0;
        {mismatches, comparisons, cycles, since, w} = '0;
        seed = 68970;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (POR_TEST / 2) @(posedge clk);
        #1 check(status_oe, 1'b1, "por status");
        check(hiz, 1'b1, "por io");
        repeat (POR_TEST + 10) @(posedge clk);
        #1 check(status_oe, 1'b0, "status release");
        check(hiz, 1'b1, "io after por");
        $display("test power_on done");
        // Another device holds status low: bits must not be taken.
        ext_stat_low = 1'b1;
        host.load(mk_image(), 64, 20, 1'b1);
        check(comp_oe, 1'b1, "status low load");
        ext_stat_low = 1'b0;
        $display("test status_low done");
        // Chain enable high: bits must not be taken.
        chain_n = 1'b1;
        host.load(mk_image(), 64, 20, 1'b0);
        check(comp_oe, 1'b1, "chain disabled load");
        chain_n = 1'b0;
        $display("test chain_off done");
        // Abort mid-image, then a full load while a neighbour holds completion.
        img = mk_image();
        host.load(img, 20, 20, 1'b0);
        ext_comp_low = 1'b1;
        host.load(img, 64, 20, 1'b0);
        check(comp_oe, 1'b0, "completion release");
        repeat (100) @(posedge clk);
        #1 check(user_mode, 1'b0, "early user");
        ext_comp_low = 1'b0;
        check_init("abort_and_hold");
        // Corrupted checksum: error holds status low, completion stays low.
        host.load(mk_image() ^ 64'h0000000000000001, 64, 20, 1'b0);
        check(status_oe, 1'b1, "error status");
        check(err, 1'b1, "error flag");
        check(comp_oe, 1'b1, "error completion");
        check(chain_out_n, 1'b1, "error chain out");
        check(user_mode, 1'b0, "error user");
        $display("test bad_image done");
        // Host restarts from scratch with fresh images.
        for (int k = 0; k < 3; k++) begin
            host.load(mk_image(), 64, 20, 1'b0);
            check_init("restart");
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
